// >>> design/csm_params.svh
`ifndef CSM_PARAMS_SVH
`define CSM_PARAMS_SVH

// Register offsets, word index on the 4-bit address port
`define CSM_ADDR_DIR_MODE 4'h0
`define CSM_ADDR_SETUP_MODE 4'h1
`define CSM_ADDR_PRESET_MODE 4'h2
`define CSM_ADDR_PROFILE 4'h3
`define CSM_ADDR_JOG1 4'h4
`define CSM_ADDR_JOG2 4'h5
`define CSM_ADDR_FMAX 4'h6
`define CSM_ADDR_STATUS 4'h7

// Reset values
`define CSM_RST_MODE 2'h3
`define CSM_RST_PROFILE 2'h1
`define CSM_RST_JOG 16'h0064
`define CSM_RST_FMAX 16'h1388

// Status word field positions
`define CSM_ST_CCW 0
`define CSM_ST_PRESET_LO 1
`define CSM_ST_PRESET_HI 2
`define CSM_ST_SETUP_LO 3
`define CSM_ST_SETUP_HI 5
`define CSM_ST_JOG 6

`endif

// >>> design/csm_pkg.sv
package csm_pkg;

  // Source selection for one command
  typedef enum logic [1:0] {
    CSM_SRC_DIG = 2'b00,
    CSM_SRC_SER = 2'b01,
    CSM_SRC_AND = 2'b10,
    CSM_SRC_OR = 2'b11
  } csm_src_type;

  // Telegram profile
  typedef enum logic [1:0] {
    CSM_PROF_STD = 2'b00,
    CSM_PROF_NATIVE = 2'b01,
    CSM_PROF_FAST = 2'b10
  } csm_prof_type;

  // Whole state of the top module
  typedef struct packed {
    csm_src_type dir_mode;
    csm_src_type setup_mode;
    csm_src_type preset_mode;
    csm_prof_type profile;
    logic [15:0] jog1;
    logic [15:0] jog2;
    logic [15:0] fmax;
    logic [15:0] rdata;
    logic ccw;
    logic [2:0] setup_no;
    logic [1:0] preset;
    logic jog_active;
    logic [15:0] jog_freq;
  } csm_state_type;

endpackage : csm_pkg

// >>> design/csm_merge.sv
`timescale 1ns/1ps
// Combines a digital and a serial code as the selected source mode asks
module csm_merge
  import csm_pkg::*;
#(
  parameter int W = 1
) (
  input wire csm_src_type mode_i,
  input wire logic [W-1:0] dig_i,
  input wire logic [W-1:0] ser_i,
  output logic [W-1:0] res_o
);

  // Bitwise selection; every code is legal
  always_comb begin
    unique case (mode_i)
      CSM_SRC_DIG: res_o = dig_i;
      CSM_SRC_SER: res_o = ser_i;
      CSM_SRC_AND: res_o = dig_i & ser_i;
      CSM_SRC_OR: res_o = dig_i | ser_i;
    endcase
  end

endmodule : csm_merge

// >>> design/csm_top.sv
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "csm_params.svh"
// Function
// - Direction: digital, serial, AND or OR
// - Single-source setup number is code plus one
// - AND/OR setup number is combined code plus one
// - All source selections reset to OR
// - Serial preset bits only in native profile
// - Profile 0 enables two bus jog speeds
// - Jog speeds clamp to limit, reset 100 Hz
// - Profile codes 0..2, reset to 1
module csm_top
  import csm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic dig_dir_i,
  input wire logic bus_dir_i,
  input wire logic [1:0] dig_setup_i,
  input wire logic [1:0] bus_setup_i,
  input wire logic [1:0] dig_preset_i,
  input wire logic [1:0] bus_preset_i,
  input wire logic bus_jog1_i,
  input wire logic bus_jog2_i,
  output logic ccw_o,
  output logic [2:0] setup_no_o,
  output logic [1:0] preset_o,
  output logic jog_active_o,
  output logic [15:0] jog_freq_o
);

  csm_state_type st_q;
  csm_state_type st_d;
  logic dir_res;
  logic [1:0] setup_res;
  logic [1:0] preset_res;
  csm_src_type preset_eff;
  logic [15:0] wclamp;

  // Outside the native profile serial preset bits are ignored
  assign preset_eff = (st_q.profile == CSM_PROF_NATIVE) ? st_q.preset_mode : CSM_SRC_DIG;

  // Write data held to the frequency limit
  assign wclamp = (wdata_i > st_q.fmax) ? st_q.fmax : wdata_i;

  // One merge per command, each with its own mode
  csm_merge #(.W(1)) u_dir (
    .mode_i(st_q.dir_mode),
    .dig_i(dig_dir_i),
    .ser_i(bus_dir_i),
    .res_o(dir_res)
  );

  csm_merge #(.W(2)) u_setup (
    .mode_i(st_q.setup_mode),
    .dig_i(dig_setup_i),
    .ser_i(bus_setup_i),
    .res_o(setup_res)
  );

  csm_merge #(.W(2)) u_preset (
    .mode_i(preset_eff),
    .dig_i(dig_preset_i),
    .ser_i(bus_preset_i),
    .res_o(preset_res)
  );

  // Next state: register writes, read data, merged commands
  always_comb begin
    st_d = st_q;
    st_d.rdata = 16'h0000;
    if (wr_i) begin
      unique case (addr_i)
        `CSM_ADDR_DIR_MODE: st_d.dir_mode = csm_src_type'(wdata_i[1:0]);
        `CSM_ADDR_SETUP_MODE: st_d.setup_mode = csm_src_type'(wdata_i[1:0]);
        `CSM_ADDR_PRESET_MODE: st_d.preset_mode = csm_src_type'(wdata_i[1:0]);
        `CSM_ADDR_PROFILE: begin
          if (wdata_i[1:0] != 2'h3) begin
            st_d.profile = csm_prof_type'(wdata_i[1:0]);
          end
        end
        `CSM_ADDR_JOG1: st_d.jog1 = wclamp;
        `CSM_ADDR_JOG2: st_d.jog2 = wclamp;
        `CSM_ADDR_FMAX: st_d.fmax = wdata_i;
        default: st_d.fmax = st_q.fmax;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        `CSM_ADDR_DIR_MODE: st_d.rdata = {14'h0000, st_q.dir_mode};
        `CSM_ADDR_SETUP_MODE: st_d.rdata = {14'h0000, st_q.setup_mode};
        `CSM_ADDR_PRESET_MODE: st_d.rdata = {14'h0000, st_q.preset_mode};
        `CSM_ADDR_PROFILE: st_d.rdata = {14'h0000, st_q.profile};
        `CSM_ADDR_JOG1: st_d.rdata = st_q.jog1;
        `CSM_ADDR_JOG2: st_d.rdata = st_q.jog2;
        `CSM_ADDR_FMAX: st_d.rdata = st_q.fmax;
        `CSM_ADDR_STATUS: begin
          st_d.rdata[`CSM_ST_CCW] = st_q.ccw;
          st_d.rdata[`CSM_ST_PRESET_HI:`CSM_ST_PRESET_LO] = st_q.preset;
          st_d.rdata[`CSM_ST_SETUP_HI:`CSM_ST_SETUP_LO] = st_q.setup_no;
          st_d.rdata[`CSM_ST_JOG] = st_q.jog_active;
        end
        default: st_d.rdata = 16'h0000; // Unmapped reads as zero
      endcase
    end
    st_d.ccw = dir_res;
    st_d.setup_no = {1'b0, setup_res} + 3'h1;
    st_d.preset = preset_res;
    // Bus jog only in profile 0, jog 1 wins over jog 2
    st_d.jog_active = (st_q.profile == CSM_PROF_STD) && (bus_jog1_i || bus_jog2_i);
    if (!st_d.jog_active) begin
      st_d.jog_freq = 16'h0000;
    end else if (bus_jog1_i) begin
      st_d.jog_freq = (st_q.jog1 > st_q.fmax) ? st_q.fmax : st_q.jog1;
    end else begin
      st_d.jog_freq = (st_q.jog2 > st_q.fmax) ? st_q.fmax : st_q.jog2;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_q.dir_mode <= csm_src_type'(`CSM_RST_MODE);
      st_q.setup_mode <= csm_src_type'(`CSM_RST_MODE);
      st_q.preset_mode <= csm_src_type'(`CSM_RST_MODE);
      st_q.profile <= csm_prof_type'(`CSM_RST_PROFILE);
      st_q.jog1 <= `CSM_RST_JOG;
      st_q.jog2 <= `CSM_RST_JOG;
      st_q.fmax <= `CSM_RST_FMAX;
      st_q.rdata <= 16'h0000;
      st_q.ccw <= 1'b0;
      st_q.setup_no <= 3'h1;
      st_q.preset <= 2'h0;
      st_q.jog_active <= 1'b0;
      st_q.jog_freq <= 16'h0000;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops
  assign rdata_o = st_q.rdata;
  assign ccw_o = st_q.ccw;
  assign setup_no_o = st_q.setup_no;
  assign preset_o = st_q.preset;
  assign jog_active_o = st_q.jog_active;
  assign jog_freq_o = st_q.jog_freq;

  // Checks on the merged commands and settings
  a_dir_and_mode: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (st_q.dir_mode == CSM_SRC_AND) |=> (ccw_o == ($past(dig_dir_i) && $past(bus_dir_i))))
    else $error("direction AND mode wrong");

  a_dir_ser_mode: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (st_q.dir_mode == CSM_SRC_SER) |=> (ccw_o == $past(bus_dir_i)))
    else $error("direction serial mode wrong");

  a_setup_dig_no: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (st_q.setup_mode == CSM_SRC_DIG) |=> (setup_no_o == 3'({1'b0, $past(dig_setup_i)} + 3'h1)))
    else $error("digital setup number wrong");

  a_setup_or_no: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (st_q.setup_mode == CSM_SRC_OR) |=> (setup_no_o == 3'({1'b0, $past(dig_setup_i | bus_setup_i)} + 3'h1)))
    else $error("OR setup number wrong");

  a_reset_defaults: assert property (
    @(posedge mclk_i)
    srst_i |=> (st_q.dir_mode == CSM_SRC_OR && st_q.setup_mode == CSM_SRC_OR &&
      st_q.preset_mode == CSM_SRC_OR && st_q.profile == CSM_PROF_NATIVE && st_q.jog1 == 16'h0064))
    else $error("reset defaults wrong");

  a_preset_ignore_ser: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (st_q.profile != CSM_PROF_NATIVE) |=> (preset_o == $past(dig_preset_i)))
    else $error("serial preset bits not ignored");

  a_jog_profile_gate: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (st_q.profile != CSM_PROF_STD) |=> !jog_active_o ##0 (jog_freq_o == 16'h0000))
    else $error("bus jog outside profile 0");

  a_jog_write_clamp: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (wr_i && addr_i == `CSM_ADDR_JOG1) |=> (st_q.jog1 <= $past(st_q.fmax)))
    else $error("jog speed above limit");

  a_profile_illegal: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (wr_i && addr_i == `CSM_ADDR_PROFILE && wdata_i[1:0] == 2'h3) |=> $stable(st_q.profile))
    else $error("illegal profile code taken");

  a_mode_independent: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (wr_i && addr_i == `CSM_ADDR_SETUP_MODE) |=> ($stable(st_q.dir_mode) && $stable(st_q.preset_mode)))
    else $error("mode write disturbed another command");

  a_dir_dig_mode: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (st_q.dir_mode == CSM_SRC_DIG) |=> (ccw_o == $past(dig_dir_i)))
    else $error("direction digital mode wrong");

  a_dir_or_mode: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (st_q.dir_mode == CSM_SRC_OR) |=> (ccw_o == ($past(dig_dir_i) || $past(bus_dir_i))))
    else $error("direction OR mode wrong");

  a_setup_ser_no: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (st_q.setup_mode == CSM_SRC_SER) |=> (setup_no_o == 3'({1'b0, $past(bus_setup_i)} + 3'h1)))
    else $error("serial setup number wrong");

  a_setup_and_no: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (st_q.setup_mode == CSM_SRC_AND) |=> (setup_no_o == 3'({1'b0, $past(dig_setup_i & bus_setup_i)} + 3'h1)))
    else $error("AND setup number wrong");

  a_preset_native_or: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (st_q.profile == CSM_PROF_NATIVE && st_q.preset_mode == CSM_SRC_OR) |=>
      (preset_o == ($past(dig_preset_i) | $past(bus_preset_i))))
    else $error("native profile preset merge wrong");

endmodule : csm_top

// >>> verif/csm_far_model.sv
`timescale 1ns/1ps
// Far side: digital terminals and the bus master's control word bits
module csm_far_model (
  input wire logic mclk_i,
  output logic [11:0] cmd_o
);
  integer seed = 32'h5660;
  initial cmd_o = '0;
  // New terminal levels and control word after every rising edge
  always @(posedge mclk_i) begin
    cmd_o <= 12'($random(seed));
  end
endmodule : csm_far_model

// >>> verif/csm_top_tb.sv
`timescale 1ns/1ps
module csm_top_tb;
  logic mclk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, ccw_o, jog_active_o;
  logic [3:0] addr_i = 0;
  logic [15:0] wdata_i = 0, rdata_o, jog_freq_o, j1, j2, fm;
  logic [11:0] c;
  logic [2:0] setup_no_o;
  logic [1:0] preset_o, prof;
  logic [1:0] md[3];
  logic [22:0] lastn;
  logic [38:0] q[$];
  int failures = 0, n_tests = 0;

  always #5 mclk_i = ~mclk_i;

  csm_far_model i_far (.mclk_i, .cmd_o(c));
  csm_top i_dut (.mclk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .dig_dir_i(c[0]), .bus_dir_i(c[1]), .dig_setup_i(c[3:2]), .bus_setup_i(c[5:4]),
    .dig_preset_i(c[7:6]), .bus_preset_i(c[9:8]), .bus_jog1_i(c[10]), .bus_jog2_i(c[11]),
    .ccw_o, .setup_no_o, .preset_o, .jog_active_o, .jog_freq_o);

  // Combine a digital and a serial code as a source mode selects
  function automatic logic [1:0] mg(input logic [1:0] m, d, s);
    case (m)
      2'h0: return d;
      2'h1: return s;
      2'h2: return d & s;
      default: return d | s;
    endcase
  endfunction : mg

  // Note each edge's expected outputs, then follow register writes
  always @(posedge mclk_i) begin
    logic [22:0] e;
    logic [15:0] r, t;
    if (srst_i) begin
      md = '{2'h3, 2'h3, 2'h3};
      prof = 2'h1;
      j1 = 16'h0064;
      j2 = 16'h0064;
      fm = 16'h1388;
      lastn = 23'h000008;
      q.push_back({16'h0000, lastn});
    end else begin
      e[0] = |mg(md[0], {1'b0, c[0]}, {1'b0, c[1]});
      e[2:1] = (prof == 2'h1) ? mg(md[2], c[7:6], c[9:8]) : c[7:6];
      e[5:3] = 3'h1 + mg(md[1], c[3:2], c[5:4]);
      e[6] = (prof == 2'h0) && (c[10] || c[11]);
      t = c[10] ? j1 : j2;
      e[22:7] = !e[6] ? 16'h0000 : (t > fm ? fm : t);
      case (addr_i)
        4'h0, 4'h1, 4'h2: r = 16'(md[addr_i]);
        4'h3: r = 16'(prof);
        4'h4: r = j1;
        4'h5: r = j2;
        4'h6: r = fm;
        4'h7: r = {9'h000, lastn[6:0]};
        default: r = 16'h0000;
      endcase
      q.push_back({rd_i ? r : 16'h0000, e});
      lastn = e;
      t = (wdata_i > fm) ? fm : wdata_i;
      if (wr_i) begin
        case (addr_i)
          4'h0, 4'h1, 4'h2: md[addr_i] = wdata_i[1:0];
          4'h3: if (wdata_i[1:0] != 2'h3) prof = wdata_i[1:0];
          4'h4: j1 = t;
          4'h5: j2 = t;
          4'h6: fm = wdata_i;
          default: ;
        endcase
      end
    end
  end

  task automatic chk_cmd(input logic [22:0] g, x);
    n_tests++;
    if (g !== x) begin
      failures++;
      $display("Error at %0t: outputs %h expected %h", $time, g, x);
    end
  endtask : chk_cmd

  task automatic chk_rd(input logic [15:0] g, x);
    n_tests++;
    if (g !== x) begin
      failures++;
      $display("Error at %0t: read %h expected %h", $time, g, x);
    end
  endtask : chk_rd

  // Compare settled results with the oldest note
  always @(negedge mclk_i) begin
    logic [38:0] n;
    if (q.size() > 0) begin
      n = q.pop_front();
      chk_cmd({jog_freq_o, jog_active_o, setup_no_o, preset_o, ccw_o}, n[22:0]);
      chk_rd(rdata_o, n[38:23]);
    end
  end

  // One register access, strobe for a single cycle
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask : acc

  task automatic conclude;
    @(negedge mclk_i);
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  initial begin
    repeat (20) @(posedge mclk_i);
    srst_i <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      for (int a = 0; a < 16; a++) acc(0, a[3:0], 16'h0000);
      acc(1, 4'h4, 16'hFFFF);
      acc(1, 4'h5, 16'h0000);
      for (int m = 0; m < 4; m++) begin
        for (int p = 0; p < 4; p++) begin
          acc(1, 4'h0, 16'hABC0 | 16'(m));
          acc(1, 4'h1, 16'(((m + 1) % 4)));
          acc(1, 4'h2, 16'(((m + 2) % 4)));
          acc(1, 4'h3, 16'(p));
          repeat (30) @(posedge mclk_i);
          acc(0, 4'h7, 16'h0000);
          acc(0, 4'h3, 16'h0000);
        end
      end
      acc(1, 4'h6, 16'h0010);
      acc(1, 4'h3, 16'h0000);
      acc(1, 4'h5, 16'h0020);
      acc(1, 4'h7, 16'hFFFF);
      acc(1, 4'h8, 16'hFFFF);
      repeat (30) @(posedge mclk_i);
      for (int a = 0; a < 9; a++) acc(0, a[3:0], 16'h0000);
      srst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      srst_i <= 1'b0;
    end
    conclude();
  end
endmodule : csm_top_tb
